// >>> logic/esclg_pkg.sv
// Shared constants and types of the eight-channel event, state and count logger.
// Assumes one 20 MHz system clock; every file that uses these imports the package.
package esclg_pkg;

  localparam int NUM_CH = 8;
  localparam int DATA_W = 32;
  localparam int CFG_BITS = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 4_000_000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_MS = 4;
  localparam int IVAL_MIN_MS = 100;
  localparam int IVAL_MAX_DAYS = 198;
  localparam int MS_PER_DAY = 86_400_000;
  localparam longint IVAL_MAX_L = longint'(IVAL_MAX_DAYS) * MS_PER_DAY / TICK_MS;
  localparam logic [31:0] IVAL_MIN_TICKS = 32'(IVAL_MIN_MS / TICK_MS);
  localparam logic [31:0] IVAL_MAX_TICKS = IVAL_MAX_L[31:0];

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHCFG = 8'h04;
  localparam logic [7:0] ADDR_IVAL = 8'h08;
  localparam logic [7:0] ADDR_STAMP = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RSTAMP = 8'h14;
  localparam logic [7:0] ADDR_RES_BASE = 8'h20;
  localparam logic [7:0] ADDR_RES_LAST = 8'h3C;

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_OVR_BIT = 2;
  localparam int STAT_LEVEL_LSB = 8;

  // Mode field encodings
  localparam logic [1:0] MODE_EVENT = 2'h0;
  localparam logic [1:0] MODE_STATE = 2'h1;
  localparam logic [1:0] MODE_COUNT = 2'h2;

  // Reset values
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;
  localparam logic [31:0] IVAL_RST = IVAL_MIN_TICKS;

  typedef enum logic [1:0] {RPT_IDLE, RPT_SCAN, RPT_SEND} esclg_rpt_e;

  function automatic logic [CFG_BITS-1:0] cfg_of(input logic [31:0] cfg, input int ch);
    cfg_of = cfg[ch*CFG_BITS +: CFG_BITS];
  endfunction

endpackage

// >>> logic/esclg_timer.sv
// Report interval timer: free-running 4 ms tick, interval counter and time stamp.
// Assumes run, interval and stamp load come from logic on the same clock.
`timescale 1ns/1ps
module esclg_timer #(
  parameter int TICK_CYCLES = esclg_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  input wire logic [31:0] ival_ticks,
  input wire logic stamp_load,
  input wire logic [31:0] stamp_wdata,
  output logic ival_end,
  output logic [31:0] stamp
);
  import esclg_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [PW-1:0] pre;
  logic [31:0] ticks;
  logic tick;

  assign tick = (pre == PRE_LAST);

  // Prescaler ignores run and advances whenever ce is high, so the stamp keeps time while stopped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre <= '0;
    end else if (ce) begin
      pre <= tick ? '0 : pre + 1'b1;
    end
  end

  // One shared interval counter for the whole board
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ticks <= '0;
      ival_end <= 1'b0;
    end else if (ce) begin
      ival_end <= 1'b0;
      if (!run) begin
        ticks <= '0;
      end else if (tick) begin
        if (ticks >= ival_ticks - 32'h0000_0001) begin
          ticks <= '0;
          ival_end <= 1'b1;
        end else begin
          ticks <= ticks + 32'h0000_0001;
        end
      end
    end
  end

  // Stamp counts 4 ms ticks from the value software loaded
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stamp <= '0;
    end else if (ce) begin
      if (stamp_load) begin
        stamp <= stamp_wdata;
      end else if (tick) begin
        stamp <= stamp + 32'h0000_0001;
      end
    end
  end

endmodule

// >>> logic/esclg_chan.sv
// One input channel: pin synchroniser, edge detect and per-mode result.
// Assumes the pin is asynchronous and ival_end is a one-cycle pulse.
`timescale 1ns/1ps
module esclg_chan (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin,
  input wire logic [esclg_pkg::CFG_BITS-1:0] cfg,
  input wire logic ival_end,
  output logic level,
  output logic [31:0] snap
);
  import esclg_pkg::*;

  logic meta;
  logic prev;
  logic en;
  logic pol;
  logic [1:0] mode;
  logic edge_hit;
  logic active;
  logic seen;
  logic [31:0] tally;
  logic [31:0] next_snap;

  assign en = cfg[CFG_EN_BIT];
  assign pol = cfg[CFG_POL_BIT];
  assign mode = cfg[CFG_MODE_LSB +: 2];

  // Two flops before anything looks at the pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end else if (ce) begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  // Polarity picks the edge and the true level
  assign edge_hit = pol ? (prev & ~level) : (~prev & level);
  assign active = level ^ pol;

  always_comb begin
    case (mode)
      MODE_EVENT: next_snap = {31'h0000_0000, seen | edge_hit};
      MODE_STATE: next_snap = {31'h0000_0000, active};
      MODE_COUNT: next_snap = tally;
      default: next_snap = 32'h0000_0000;
    endcase
  end

  // Count saturates rather than wrapping on very long intervals
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tally <= '0;
    end else if (ce) begin
      if (!en || ival_end) begin
        tally <= (en && edge_hit) ? 32'h0000_0001 : 32'h0000_0000;
      end else if (edge_hit && tally != 32'hFFFF_FFFF) begin
        tally <= tally + 32'h0000_0001;
      end
    end
  end

  // At most one event flagged per interval
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seen <= 1'b0;
    end else if (ce) begin
      if (!en || ival_end) begin
        seen <= 1'b0;
      end else if (edge_hit) begin
        seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      snap <= '0;
    end else if (ce) begin
      if (!en) begin
        snap <= '0;
      end else if (ival_end) begin
        snap <= next_snap;
      end
    end
  end

endmodule

// >>> logic/esclg_top.sv
// What this block does
// - each channel has its own enable bit, independent of the others
// - each channel picks event, state or count mode on its own
// - mode times polarity gives six settings, chosen per channel
// - report interval from 100 ms to 198 days in 4 ms steps
// - one interval setting serves every channel of the board
// - reports repeat at each interval end that finds the streamer idle, until software stops the run
// - each interval end reports only enabled channels, at most eight
// - every report carries a time stamp
// - count mode adds one per edge of the chosen polarity
// - count mode reports the interval total, then restarts from zero
// - event mode reports at most one occurrence per interval
// - state mode samples the input only at the interval end
// - polarity decides whether high or low is the true level
//
// Top of the logger: APB register slave, eight channels, interval timer
// and the report streamer. Assumes the report sink runs on clk_sys.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module esclg_top #(
  parameter int NCH = esclg_pkg::NUM_CH,
  parameter int TICK_CYCLES = esclg_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [NCH-1:0] ch_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rpt_valid,
  input wire logic rpt_ready,
  output logic [2:0] rpt_chan,
  output logic [1:0] rpt_mode,
  output logic rpt_pol,
  output logic [31:0] rpt_value,
  output logic [31:0] rpt_stamp
);
  import esclg_pkg::*;

  if (NCH < 1 || NCH > NUM_CH) begin : g_chk_nch
    $error("NCH must lie between 1 and 8");
  end

  // The timer checks this too, but a bad prescaler should fail here as well
  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end

  localparam logic [2:0] LAST_CH = 3'(NCH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic run;
  logic [31:0] chcfg;
  logic [31:0] ival;
  logic ovr;
  logic [31:0] rstamp;
  logic [NCH-1:0] pend;
  logic [2:0] idx;
  esclg_rpt_e state;

  logic ival_end;
  logic [31:0] stamp;
  logic [NCH-1:0] level;
  logic [31:0] snap [NCH];

  logic wr_en;
  logic setup;
  logic stamp_load;
  logic boundary;
  logic [31:0] next_prdata;
  logic next_err;
  logic [31:0] ival_clamped;
  logic [7:0] level_ext;
  logic wr_ctrl;
  logic wr_chcfg;
  logic wr_ival;
  logic wr_status;
  logic [CFG_BITS-1:0] cfg_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_is_result(input logic [7:0] a);
    addr_is_result = (a >= ADDR_RES_BASE) && (a <= ADDR_RES_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] result_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_RES_BASE;
    result_index = off[4:2];
  endfunction

  // One decoder for every register write strobe
  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] ra);
    wr_hit = we && (a == ra);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channels and timer

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Each channel takes only its own slice of the config word
    esclg_chan u_chan (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .pin(ch_in[c]),
      .cfg(cfg_of(chcfg, c)),
      .ival_end(ival_end),
      .level(level[c]),
      .snap(snap[c])
    );
  end

  esclg_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .run(run),
    .ival_ticks(ival),
    .stamp_load(stamp_load),
    .stamp_wdata(pwdata),
    .ival_end(ival_end),
    .stamp(stamp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Setup cycle is used to prepare read data, so the access phase never waits
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign stamp_load = wr_hit(wr_en, paddr, ADDR_STAMP);
  assign wr_ctrl = wr_hit(wr_en, paddr, ADDR_CTRL);
  assign wr_chcfg = wr_hit(wr_en, paddr, ADDR_CHCFG);
  assign wr_ival = wr_hit(wr_en, paddr, ADDR_IVAL);
  assign wr_status = wr_hit(wr_en, paddr, ADDR_STATUS);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setup;
    end
  end

  always_comb begin
    next_err = 1'b0;
    next_prdata = 32'h0000_0000;
    if (addr_is_result(paddr)) begin
      if (result_index(paddr) <= LAST_CH) begin
        next_prdata = snap[result_index(paddr)];
      end else begin
        next_err = 1'b1;
      end
    end else begin
      case (paddr)
        ADDR_CTRL: next_prdata[CTRL_RUN_BIT] = run;
        ADDR_CHCFG: next_prdata = chcfg;
        ADDR_IVAL: next_prdata = ival;
        ADDR_STAMP: next_prdata = stamp;
        ADDR_STATUS: begin
          next_prdata[STAT_RUN_BIT] = run;
          next_prdata[STAT_BUSY_BIT] = (state != RPT_IDLE);
          next_prdata[STAT_OVR_BIT] = ovr;
          next_prdata[STAT_LEVEL_LSB +: 8] = level_ext;
        end
        ADDR_RSTAMP: next_prdata = rstamp;
        default: next_err = 1'b1;
      endcase
    end
  end

  assign level_ext = 8'(level);

  // Reads have no side effects, so latching data in setup is safe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Run stays set until software clears it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        run <= pwdata[CTRL_RUN_BIT];
      end
    end
  end

  // Four bits per channel: enable, polarity, two mode bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chcfg <= CHCFG_RST;
    end else if (ce) begin
      if (wr_chcfg) begin
        chcfg <= pwdata;
      end
    end
  end

  // Out-of-range intervals are pulled to the nearest legal bound
  always_comb begin
    if (pwdata < IVAL_MIN_TICKS) begin
      ival_clamped = IVAL_MIN_TICKS;
    end else if (pwdata > IVAL_MAX_TICKS) begin
      ival_clamped = IVAL_MAX_TICKS;
    end else begin
      ival_clamped = pwdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ival <= IVAL_RST;
    end else if (ce) begin
      if (wr_ival) begin
        ival <= ival_clamped;
      end
    end
  end

  // Overrun: a boundary while a report pass is still draining
  // New overrun wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovr <= 1'b0;
    end else if (ce) begin
      if (boundary && state != RPT_IDLE) begin
        ovr <= 1'b1;
      end else if (wr_status && pwdata[STAT_OVR_BIT]) begin
        ovr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report streamer

  assign boundary = ival_end & run;
  // Settings of the channel being scanned, copied into the report
  assign cfg_sel = cfg_of(chcfg, int'(idx));

  // Stamp of the boundary is held for every report of the pass
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstamp <= '0;
    end else if (ce) begin
      if (boundary && state == RPT_IDLE) begin
        rstamp <= stamp;
      end
    end
  end

  // Walks channels in order; a slow sink loses the next boundary, and reports still pending take the newer results
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= RPT_IDLE;
      pend <= '0;
      idx <= '0;
    end else if (ce) begin
      case (state)
        RPT_IDLE: begin
          if (boundary) begin
            for (int c = 0; c < NCH; c++) begin
              pend[c] <= chcfg[c*CFG_BITS + CFG_EN_BIT];
            end
            idx <= '0;
            state <= RPT_SCAN;
          end
        end
        RPT_SCAN: begin
          if (pend[idx]) begin
            state <= RPT_SEND;
          end else if (idx == LAST_CH) begin
            state <= RPT_IDLE;
          end else begin
            idx <= idx + 3'h1;
          end
        end
        RPT_SEND: begin
          if (rpt_ready) begin
            pend[idx] <= 1'b0;
            if (idx == LAST_CH) begin
              state <= RPT_IDLE;
            end else begin
              idx <= idx + 3'h1;
              state <= RPT_SCAN;
            end
          end
        end
        default: state <= RPT_IDLE;
      endcase
    end
  end

  // Report outputs are loaded in the scan cycle and held until taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rpt_valid <= 1'b0;
      rpt_chan <= '0;
      rpt_mode <= '0;
      rpt_pol <= 1'b0;
      rpt_value <= '0;
      rpt_stamp <= '0;
    end else if (ce) begin
      if (state == RPT_SCAN && pend[idx]) begin
        rpt_valid <= 1'b1;
        rpt_chan <= idx;
        rpt_mode <= cfg_sel[CFG_MODE_LSB +: 2];
        rpt_pol <= cfg_sel[CFG_POL_BIT];
        rpt_value <= snap[idx];
        rpt_stamp <= rstamp;
      end else if (state == RPT_SEND && rpt_ready) begin
        rpt_valid <= 1'b0;
      end
    end
  end

endmodule

// >>> testbench/esclg_chk.sv
// Checker for the logger top ports: APB answer timing and report stream.
// Assumes ce stays high while a transfer or report is in flight; bound to every esclg_top.
`timescale 1ns/1ps
module esclg_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rpt_valid,
  input wire logic rpt_ready,
  input wire logic [2:0] rpt_chan,
  input wire logic [1:0] rpt_mode,
  input wire logic [31:0] rpt_value,
  input wire logic [31:0] rpt_stamp
);
  import esclg_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Pass tracking: a pass ends after 20 quiet cycles, far below one interval
  logic [4:0] idle;
  logic in_pass;
  logic [2:0] last_ch;
  logic [31:0] last_st;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idle <= 5'h00;
      in_pass <= 1'b0;
      last_ch <= 3'h0;
      last_st <= 32'h0000_0000;
    end else begin
      idle <= rpt_valid ? 5'h00 : (idle == 5'h14 ? idle : idle + 5'h01);
      if (rpt_valid && rpt_ready) begin
        in_pass <= 1'b1;
        last_ch <= rpt_chan;
        last_st <= rpt_stamp;
      end else if (idle == 5'h13) begin
        in_pass <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_apb_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && paddr == 8'h18 |=> pslverr)
    else $error("unmapped address not refused");
  a_ival_ok: assert property (psel && !penable && paddr == ADDR_IVAL |=> !pslverr)
    else $error("interval register refused");
  a_rpt_hold: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_chan)
    && $stable(rpt_value) && $stable(rpt_stamp))
    else $error("report changed before acceptance");
  a_rpt_release: assert property (rpt_valid && rpt_ready |=> !rpt_valid)
    else $error("report offered again after acceptance");
  a_rpt_order: assert property (rpt_valid && in_pass |-> rpt_chan > last_ch)
    else $error("report channels not ascending");
  a_pass_stamp: assert property (rpt_valid && in_pass |-> rpt_stamp == last_st)
    else $error("stamp differs within one pass");
  a_flag_modes: assert property (rpt_valid && rpt_mode != MODE_COUNT |-> rpt_value <= 32'h1)
    else $error("event or state result above one");
endmodule

bind esclg_top esclg_chk chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .rpt_valid(rpt_valid),
  .rpt_ready(rpt_ready), .rpt_chan(rpt_chan), .rpt_mode(rpt_mode), .rpt_value(rpt_value),
  .rpt_stamp(rpt_stamp));

// >>> testbench/esclg_sink.sv
// Report sink in place of the host: accepts reports, stalls when slow is set.
// Assumes the same clock as the logger; ready is a registered level.
`timescale 1ns/1ps
module esclg_sink (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slow,
  input wire logic rpt_valid,
  output logic rpt_ready,
  input wire logic [2:0] rpt_chan,
  input wire logic [1:0] rpt_mode,
  input wire logic rpt_pol,
  input wire logic [31:0] rpt_value,
  input wire logic [31:0] rpt_stamp
);
  logic [1:0] ph;
  int n_rpt;
  int cnt [8];
  logic [31:0] val [8];
  logic [31:0] stamp;
  logic [1:0] mode [8];
  logic [7:0] pol;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      rpt_ready <= 1'b0;
      n_rpt <= 0;
      stamp <= 32'h0000_0000;
      pol <= 8'h00;
      for (int c = 0; c < 8; c++) begin
        cnt[c] <= 0;
        val[c] <= 32'h0000_0000;
        mode[c] <= 2'h0;
      end
    end else begin
      ph <= ph + 2'h1;
      // Stalls three cycles in four so held reports are exercised
      rpt_ready <= !slow || ph == 2'h2;
      if (rpt_valid && rpt_ready) begin
        n_rpt <= n_rpt + 1;
        cnt[rpt_chan] <= cnt[rpt_chan] + 1;
        val[rpt_chan] <= rpt_value;
        stamp <= rpt_stamp;
        mode[rpt_chan] <= rpt_mode;
        pol[rpt_chan] <= rpt_pol;
      end
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the logger: APB master, pin stimulus, report sink.
// Assumes a short tick of 8 cycles so one 25-tick interval is 200 cycles.
`timescale 1ns/1ps
module testbench;
  import esclg_pkg::*;
  localparam logic [7:0] IDLE = 8'h72;
  // Mode and polarity that each channel was set to, two mode bits per channel
  localparam logic [15:0] EXP_MODE = 16'h142A;
  localparam logic [7:0] EXP_POL = 8'h52;
  logic clk_sys, rstn, psel, penable, pwrite, slow, pready, pslverr, err, ce;
  logic rpt_valid, rpt_ready, rpt_pol;
  logic [7:0] paddr, ch_in;
  logic [31:0] pwdata, prdata, rpt_value, rpt_stamp, q, s1;
  logic [2:0] rpt_chan;
  logic [1:0] rpt_mode;
  int error_cnt, num_checks, cyc;
  esclg_top #(.TICK_CYCLES(8)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .ch_in(ch_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_chan(rpt_chan), .rpt_mode(rpt_mode), .rpt_pol(rpt_pol),
    .rpt_value(rpt_value), .rpt_stamp(rpt_stamp));
  esclg_sink snk (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_chan(rpt_chan), .rpt_mode(rpt_mode), .rpt_pol(rpt_pol),
    .rpt_value(rpt_value), .rpt_stamp(rpt_stamp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle so no signal is set twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    cmp32($sformatf("read %h", a), exp, q);
    cmp32($sformatf("error %h", a), {31'h0, exp_err}, {31'h0, err});
  endtask
  task automatic wait_pass();
    int base;
    base = snk.n_rpt;
    for (int n = 0; n < 400 && snk.n_rpt < base + 7; n++) @(posedge clk_sys);
    cmp32("reports per pass", 32'd7, 32'(snk.n_rpt - base));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_CHCFG, CHCFG_RST, 1'b0);
    rd_chk(ADDR_IVAL, IVAL_RST, 1'b0);
    rd_chk(8'h18, 32'h0000_0000, 1'b1);
    apb(1'b1, ADDR_IVAL, 32'h0000_0001);
    rd_chk(ADDR_IVAL, IVAL_MIN_TICKS, 1'b0);
    apb(1'b1, ADDR_IVAL, 32'hFFFF_FFFF);
    rd_chk(ADDR_IVAL, IVAL_MAX_TICKS, 1'b0);
    apb(1'b1, ADDR_IVAL, 32'h0000_001A);
    rd_chk(ADDR_IVAL, 32'h0000_001A, 1'b0);
    apb(1'b1, ADDR_IVAL, 32'h0000_0019);
    $display("t_regs done");
  endtask
  // Six settings over seven enabled channels; channel 2 disabled
  task automatic t_modes();
    apb(1'b1, ADDR_CHCFG, 32'h1753_18B9);
    rd_chk(ADDR_CHCFG, 32'h1753_18B9, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    wait_pass();
    slow <= 1'b1;
    // Three pulses; channel 5 dips low but is high again at the boundary
    repeat (3) begin
      ch_in <= IDLE ^ 8'h3B;
      repeat (4) @(posedge clk_sys);
      ch_in <= IDLE;
      repeat (4) @(posedge clk_sys);
    end
    wait_pass();
    s1 = snk.stamp;
    for (int c = 0; c < 8; c++) begin
      if (c == 0 || c == 1) cmp32($sformatf("count ch%0d", c), 32'h3, snk.val[c]);
      if (c == 3 || c == 4) cmp32($sformatf("event ch%0d", c), 32'h1, snk.val[c]);
      if (c >= 5) cmp32($sformatf("flag ch%0d", c), {31'h0, c == 5}, snk.val[c]);
      if (c != 2) begin
        cmp32($sformatf("mode ch%0d", c), 32'(EXP_MODE[2*c +: 2]), 32'(snk.mode[c]));
        cmp32($sformatf("pol ch%0d", c), 32'(EXP_POL[c]), 32'(snk.pol[c]));
      end
    end
    rd_chk(ADDR_RES_BASE, 32'h0000_0003, 1'b0);
    rd_chk(ADDR_RES_BASE + 8'h08, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_RSTAMP, s1, 1'b0);
    wait_pass();
    cmp32("count cleared", 32'h0, snk.val[0]);
    cmp32("event cleared", 32'h0, snk.val[3]);
    cmp32("stamp step", 32'h19, snk.stamp - s1);
    cmp32("disabled reports", 32'h0, 32'(snk.cnt[2]));
    $display("t_modes done");
  endtask
  task automatic t_stop();
    int base;
    wait_pass();
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    base = snk.n_rpt;
    repeat (600) @(posedge clk_sys);
    cmp32("reports after stop", 32'(base), 32'(snk.n_rpt));
    rd_chk(ADDR_STATUS, 32'h0000_7200, 1'b0);
    apb(1'b1, ADDR_STAMP, 32'h0000_1000);
    // Freeze far longer than one tick; the loaded stamp may move by one at most
    ce <= 1'b0;
    repeat (400) @(posedge clk_sys);
    ce <= 1'b1;
    apb(1'b0, ADDR_STAMP, 32'h0000_0000);
    cmp32("stamp frozen by ce", 32'h1, {31'h0, q - 32'h0000_1000 <= 32'h1});
    $display("t_stop done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    slow = 1'b0;
    ce = 1'b1;
    ch_in = IDLE;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_modes();
    t_stop();
    close_out();
  end
endmodule
